// ===== logic/reqdec_regs.vh
// constants for the request packet command decoder
`ifndef REQDEC_REGS_VH
`define REQDEC_REGS_VH
// ==========================================
// primary opcodes
`define OP_RD 4'h0
`define OP_RD_ALT 4'h1
`define OP_WSEQ 4'h4
`define OP_WSEQ_ALT 4'h5
`define OP_RREG 4'h6
`define OP_WREG 4'h7
`define OP_WNSQ 4'h8
`define OP_WNSQ_ALT 4'h9
`define OP_WBNS 4'hC
`define OP_WBNS_ALT 4'hD
`define OP_BROADCAST_REGISTER_WRITE 4'hF
// ==========================================
// extended opcodes (mask modes and read kinds)
`define XOP_NPB 2'h0
`define XOP_DPB 2'h1
`define XOP_BPB 2'h2
`define XOP_MPB 2'h3
`define XOP_RSEQ 2'h0
`define XOP_RNSQ 2'h1
// ==========================================
// command codes on the CMD output
`define CMD_NONE 4'h0
`define CMD_RSEQ 4'h1
`define CMD_RNSQ 4'h2
`define CMD_WSEQ 4'h3
`define CMD_WNSQ 4'h4
`define CMD_WBNS 4'h5
`define CMD_RREG 4'h6
`define CMD_WREG 4'h7
`define CMD_BROADCAST_REGISTER_WRITE 4'h8
`define CMD_RSRV 4'hF
// ==========================================
// request packet: 6 words of 8 bits (3 cycles x even/odd tick)
`define REQ_WORDS 3'h6
`define REQ_LAST 3'h5
// bit positions inside the 48-bit assembled request
`define F_START 47
`define F_OP_HI 46
`define F_OP_LO 43
`define F_OPX_HI 42
`define F_OPX_LO 41
`define F_CLOSE 40
`define F_CNT_HI 39
`define F_CNT_LO 32
`define F_ADR_HI 31
`define F_ADR_LO 0
// ==========================================
// fifo
`define FIFO_W 8
`define FIFO_D 8
`define FIFO_AW 3
`endif

// ===== logic/req_fifo.v
// fifo holding incoming request bytes
`timescale 1ns/1ps
module req_fifo #(
  parameter W = 8,
  parameter D = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire rst,
  input wire [W-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [W-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp;
  reg [AW-1:0] rp;
  reg [AW:0] cnt;
  wire push;
  wire pop;
  assign in_ready = (cnt != D);
  assign out_valid = (cnt != 0);
  assign out_data = mem[rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // ==========================================
  // storage and pointers
  always @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
    if (rst) begin
      wp <= {AW{1'b0}};
      rp <= {AW{1'b0}};
      cnt <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp <= wp + 1'b1;
      end
      if (pop) begin
        rp <= rp + 1'b1;
      end
      if (push && !pop) begin
        cnt <= cnt + 1'b1;
      end else if (pop && !push) begin
        cnt <= cnt - 1'b1;
      end
    end
  end
endmodule // req_fifo

// ===== logic/op_decode.v
// combinational opcode decoder
`timescale 1ns/1ps
`include "reqdec_regs.vh"
module op_decode (
  input wire [3:0] primary_opcode,
  input wire [1:0] extended_opcode,
  output reg [3:0] cmd,
  output reg [1:0] mask_mode,
  output reg alt,
  output reg wants_wdata,
  output reg wants_rdata,
  output reg wants_serial_addr
);
  always @* begin
    cmd = `CMD_RSRV;
    mask_mode = `XOP_NPB;
    alt = primary_opcode[0] && (primary_opcode != `OP_WREG) && (primary_opcode != `OP_BROADCAST_REGISTER_WRITE);
    case (primary_opcode)
      `OP_RD, `OP_RD_ALT: begin
        if (extended_opcode == `XOP_RSEQ) begin
          cmd = `CMD_RSEQ;
        end else if (extended_opcode == `XOP_RNSQ) begin
          cmd = `CMD_RNSQ;
        end
      end
      `OP_WSEQ, `OP_WSEQ_ALT: begin
        cmd = `CMD_WSEQ;
        mask_mode = extended_opcode;
      end
      `OP_WNSQ, `OP_WNSQ_ALT: begin
        cmd = `CMD_WNSQ;
        mask_mode = extended_opcode;
      end
      `OP_WBNS, `OP_WBNS_ALT: begin
        if (extended_opcode != `XOP_BPB) begin
          cmd = `CMD_WBNS;
          mask_mode = extended_opcode;
        end
      end
      `OP_RREG: begin
        if (extended_opcode == 2'h0) begin
          cmd = `CMD_RREG;
        end
      end
      `OP_WREG: begin
        if (extended_opcode == 2'h0) begin
          cmd = `CMD_WREG;
        end
      end
      `OP_BROADCAST_REGISTER_WRITE: begin
        if (extended_opcode == 2'h0) begin
          cmd = `CMD_BROADCAST_REGISTER_WRITE;
        end
      end
      default: begin
        cmd = `CMD_RSRV;
      end
    endcase
    if (cmd == `CMD_RSRV) begin
      alt = 1'b0;
    end
    wants_rdata = (cmd == `CMD_RSEQ) || (cmd == `CMD_RNSQ) || (cmd == `CMD_RREG);
    wants_wdata = (cmd == `CMD_WSEQ) || (cmd == `CMD_WNSQ) || (cmd == `CMD_WBNS)
      || (cmd == `CMD_WREG) || (cmd == `CMD_BROADCAST_REGISTER_WRITE);
    wants_serial_addr = (cmd == `CMD_WNSQ) || (cmd == `CMD_WBNS);
  end
endmodule // op_decode

// ===== logic/request_packet_command_decoder.v
// request packet framer and command decoder
`timescale 1ns/1ps
`include "reqdec_regs.vh"
module request_packet_command_decoder (
  input wire MCLK,
  input wire RST,
  input wire [7:0] REQ_BYTE,
  input wire REQ_VALID,
  output wire REQ_READY,
  input wire START_BIT,
  input wire AWAIT_ACK,
  input wire DEVICE_SELECT_MATCH,
  input wire TAKE,
  output reg CMD_VALID,
  output reg [3:0] CMD,
  output reg [1:0] MASK_MODE,
  output reg ALT,
  output reg PERFORM,
  output reg NO_OKAY_ACK,
  output reg WANTS_WDATA,
  output reg WANTS_RDATA,
  output reg WANTS_SERIAL_ADDR,
  output reg [35:0] ADDRESS,
  output reg [4:0] OCT_COUNT,
  output reg [5:0] DATA_OCTBYTES,
  output reg [5:0] MASK_OCTBYTES,
  output reg [7:0] FIRST_BYTE_MASK,
  output reg [7:0] LAST_BYTE_MASK,
  output reg CLOSE,
  output reg USE_MASK_DATA_REGISTER_MASK,
  output reg USE_MASK_DATA_REGISTER_DATA,
  output reg LOAD_MASK_DATA_REGISTER,
  output reg FRAMING,
  output reg [2:0] PKT_CYCLE,
  output reg PKT_ODD_TICK
);
  localparam S_IDLE = 3'b001;
  localparam S_FRAME = 3'b010;
  localparam S_HOLD = 3'b100;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [2:0] tick;
  reg [47:0] shreg;
  wire [7:0] f_byte;
  wire f_valid;
  wire f_ready;
  wire [3:0] d_cmd;
  wire [1:0] d_mode;
  wire d_alt;
  wire d_wd;
  wire d_rd;
  wire d_sa;
  wire [47:0] full_req;
  wire [3:0] req_op;
  wire [1:0] req_opx;
  wire req_close;
  wire [7:0] req_count;
  wire [31:0] req_adr;
  wire last_byte;
  reg [5:0] next_data_octbytes;
  reg [5:0] next_mask_octbytes;
  // ==========================================
  // byte masks from low bits
  function [7:0] ls_mask;
    input [2:0] a;
    begin
      ls_mask = 8'hFF << a;
    end
  endfunction
  function [7:0] ms_mask;
    input [2:0] c;
    begin
      ms_mask = 8'hFF >> (3'h7 - c);
    end
  endfunction
  // ==========================================
  // command classes used by several outputs
  function is_mem_write;
    input [3:0] c;
    begin
      is_mem_write = (c == `CMD_WSEQ) || (c == `CMD_WNSQ) || (c == `CMD_WBNS);
    end
  endfunction
  function is_reg_cmd;
    input [3:0] c;
    begin
      is_reg_cmd = (c == `CMD_RREG) || (c == `CMD_WREG) || (c == `CMD_BROADCAST_REGISTER_WRITE);
    end
  endfunction
  // reads get masks too, for the consumer's information only
  function is_contig;
    input [3:0] c;
    begin
      is_contig = (c == `CMD_WSEQ) || (c == `CMD_RSEQ) || (c == `CMD_RNSQ);
    end
  endfunction
  // ==========================================
  // input buffer; drains only while framing
  // device only receives request bytes
  req_fifo #(
    .W(`FIFO_W),
    .D(`FIFO_D),
    .AW(`FIFO_AW)
  ) u_fifo (
    .clk(MCLK),
    .rst(RST),
    .in_data(REQ_BYTE),
    .in_valid(REQ_VALID),
    .in_ready(REQ_READY),
    .out_data(f_byte),
    .out_valid(f_valid),
    .out_ready(f_ready)
  );
  assign f_ready = (state == S_FRAME);
  assign full_req = {shreg[39:0], f_byte};
  assign req_op = full_req[`F_OP_HI:`F_OP_LO];
  assign req_opx = full_req[`F_OPX_HI:`F_OPX_LO];
  assign req_close = full_req[`F_CLOSE];
  assign req_count = full_req[`F_CNT_HI:`F_CNT_LO];
  assign req_adr = full_req[`F_ADR_HI:`F_ADR_LO];
  // sixth byte at the fifo head completes the request this edge
  assign last_byte = (state == S_FRAME) && f_valid && (tick == `REQ_LAST);
  op_decode u_dec (
    .primary_opcode(req_op),
    .extended_opcode(req_opx),
    .cmd(d_cmd),
    .mask_mode(d_mode),
    .alt(d_alt),
    .wants_wdata(d_wd),
    .wants_rdata(d_rd),
    .wants_serial_addr(d_sa)
  );
  // ==========================================
  // octbyte split
  // byte-mask octbytes ride beside the data, bit masks share the count
  always @* begin
    next_data_octbytes = {1'b0, req_count[7:3]} + 6'h01;
    next_mask_octbytes = 6'h00;
    if (d_cmd == `CMD_WBNS) begin
      next_mask_octbytes = {4'h0, req_count[7:6]} + 6'h01;
    end else if (is_mem_write(d_cmd) && d_mode == `XOP_BPB) begin
      next_data_octbytes = {2'h0, req_count[7:4]} + 6'h01;
      next_mask_octbytes = {2'h0, req_count[7:4]} + 6'h01;
    end
  end
  // ==========================================
  // state machine
  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (START_BIT && !AWAIT_ACK) begin
          next_state = S_FRAME;
        end
      end
      S_FRAME: begin
        if (f_valid && tick == `REQ_LAST) begin
          next_state = S_HOLD;
        end
      end
      // hold blocks a new start until the consumer has taken the command
      S_HOLD: begin
        if (TAKE) begin
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end
  always @(posedge MCLK) begin
    if (RST) begin
      state <= S_IDLE;
      tick <= 3'h0;
      shreg <= 48'h0000_0000_0000;
    end else begin
      state <= next_state;
      if (state == S_IDLE) begin
        tick <= 3'h0;
      end else if (state == S_FRAME && f_valid) begin
        tick <= tick + 3'h1;
        // shift in one byte per pop; the head byte completes the word
        shreg <= full_req;
      end
    end
  end
  // ==========================================
  // status outputs
  always @(posedge MCLK) begin
    if (RST) begin
      FRAMING <= 1'b0;
      PKT_CYCLE <= 3'h0;
      PKT_ODD_TICK <= 1'b0;
    end else begin
      FRAMING <= (next_state == S_FRAME);
      PKT_CYCLE <= {1'b0, tick[2:1]};
      PKT_ODD_TICK <= tick[0];
    end
  end
  // ==========================================
  // command handshake
  // valid stands until taken, so a slow consumer never loses a decode
  always @(posedge MCLK) begin
    if (RST) begin
      CMD_VALID <= 1'b0;
    end else if (last_byte) begin
      CMD_VALID <= 1'b1;
    end else if (state == S_HOLD && TAKE) begin
      CMD_VALID <= 1'b0;
    end
  end
  // ==========================================
  // decoded command register
  always @(posedge MCLK) begin
    if (RST) begin
      CMD <= `CMD_NONE;
      MASK_MODE <= `XOP_NPB;
      ALT <= 1'b0;
      PERFORM <= 1'b0;
      NO_OKAY_ACK <= 1'b0;
      WANTS_WDATA <= 1'b0;
      WANTS_RDATA <= 1'b0;
      WANTS_SERIAL_ADDR <= 1'b0;
      USE_MASK_DATA_REGISTER_MASK <= 1'b0;
      USE_MASK_DATA_REGISTER_DATA <= 1'b0;
      LOAD_MASK_DATA_REGISTER <= 1'b0;
    end else if (last_byte) begin
      CMD <= d_cmd;
      ALT <= d_alt;
      PERFORM <= (d_cmd == `CMD_BROADCAST_REGISTER_WRITE) || (DEVICE_SELECT_MATCH && d_cmd != `CMD_RSRV);
      NO_OKAY_ACK <= (d_cmd == `CMD_BROADCAST_REGISTER_WRITE);
      WANTS_WDATA <= d_wd;
      WANTS_RDATA <= d_rd;
      WANTS_SERIAL_ADDR <= d_sa;
      MASK_MODE <= d_mode;
      USE_MASK_DATA_REGISTER_MASK <= is_mem_write(d_cmd) && d_mode == `XOP_DPB;
      USE_MASK_DATA_REGISTER_DATA <= is_mem_write(d_cmd) && d_mode == `XOP_MPB;
      // a load from an unselected device would corrupt its mask register
      LOAD_MASK_DATA_REGISTER <= is_mem_write(d_cmd) && d_mode == `XOP_BPB && DEVICE_SELECT_MATCH;
    end
  end
  // ==========================================
  // address, count and byte masks
  always @(posedge MCLK) begin
    if (RST) begin
      ADDRESS <= 36'h0_0000_0000;
      OCT_COUNT <= 5'h00;
      DATA_OCTBYTES <= 6'h00;
      MASK_OCTBYTES <= 6'h00;
      FIRST_BYTE_MASK <= 8'h00;
      LAST_BYTE_MASK <= 8'h00;
      CLOSE <= 1'b0;
    end else if (last_byte) begin
      // only 32 address bits travel in the request; the top four read as zero
      ADDRESS <= {4'h0, req_adr};
      OCT_COUNT <= req_count[7:3];
      if (is_contig(d_cmd)) begin
        FIRST_BYTE_MASK <= ls_mask(req_adr[2:0]);
        LAST_BYTE_MASK <= ms_mask(req_count[2:0]);
      end else begin
        FIRST_BYTE_MASK <= 8'hFF;
        LAST_BYTE_MASK <= 8'hFF;
      end
      // register commands carry no restore flag
      CLOSE <= (is_reg_cmd(d_cmd) || d_cmd == `CMD_RSRV) ? 1'b0 : req_close;
      DATA_OCTBYTES <= next_data_octbytes;
      MASK_OCTBYTES <= next_mask_octbytes;
    end
  end
endmodule // request_packet_command_decoder

// ===== verif/reqdec_properties.sv
// port assertions for the request packet command decoder
`timescale 1ns/1ps
`include "reqdec_regs.vh"
module reqdec_properties (
  input wire MCLK,
  input wire RST,
  input wire START_BIT,
  input wire AWAIT_ACK,
  input wire TAKE,
  input wire CMD_VALID,
  input wire [3:0] CMD,
  input wire PERFORM,
  input wire NO_OKAY_ACK,
  input wire WANTS_WDATA,
  input wire WANTS_SERIAL_ADDR,
  input wire LOAD_MASK_DATA_REGISTER,
  input wire FRAMING,
  input wire [35:0] ADDRESS,
  input wire [7:0] FIRST_BYTE_MASK
);
  default clocking
    @(posedge MCLK);
  endclocking
  default disable iff (RST);
  // ==========================================
  // framing
  sequence s_start;
    START_BIT && !AWAIT_ACK && !FRAMING && !CMD_VALID;
  endsequence
  sequence s_frame;
    FRAMING ##[6:40] CMD_VALID;
  endsequence
  frame_start_a: assert property (s_start |=> s_frame)
    else $error("frame did not start or end in time");
  await_block_a: assert property (AWAIT_ACK && !FRAMING |=> !FRAMING)
    else $error("framing began while awaiting ack");
  cmd_hold_a: assert property (CMD_VALID && !TAKE |=> CMD_VALID && $stable(CMD))
    else $error("command dropped or changed before take");
  take_drop_a: assert property (CMD_VALID && TAKE |=> !CMD_VALID)
    else $error("command stayed after take");
  // ==========================================
  // decode results
  no_okay_a: assert property (CMD_VALID |-> NO_OKAY_ACK == (CMD == `CMD_BROADCAST_REGISTER_WRITE))
    else $error("no okay flag wrong");
  bcast_perform_a: assert property (CMD_VALID && CMD == `CMD_BROADCAST_REGISTER_WRITE |-> PERFORM)
    else $error("broadcast not performed");
  rsrv_quiet_a: assert property (CMD_VALID && CMD == `CMD_RSRV |->
    !PERFORM && !WANTS_WDATA && !WANTS_SERIAL_ADDR && !LOAD_MASK_DATA_REGISTER)
    else $error("reserved command has effect");
  seq_mask_a: assert property (CMD_VALID && CMD == `CMD_WSEQ |->
    FIRST_BYTE_MASK == (8'hFF << ADDRESS[2:0]))
    else $error("first byte mask wrong");
endmodule // reqdec_properties
bind request_packet_command_decoder reqdec_properties u_props (.*);

// ===== verif/master_model.sv
// channel master model sending request bytes
`timescale 1ns/1ps
module master_model (
  input wire MCLK,
  input wire REQ_READY,
  output logic [7:0] REQ_BYTE,
  output logic REQ_VALID,
  output logic START_BIT
);
  initial begin
    REQ_BYTE = 8'h00;
    REQ_VALID = 0;
    START_BIT = 0;
  end
  // master sends packets
  // bytes msb first; held until taken, stalls when full
  task automatic push(logic [47:0] p, logic rel);
    logic r;
    for (int i = 5; i >= 0; i--) begin
      REQ_BYTE = p[i*8 +: 8];
      REQ_VALID = 1;
      do begin
        @(negedge MCLK) r = REQ_READY;
        @(posedge MCLK);
      end while (!r);
      #1;
    end
    // released line must not keep the last value
    if (rel) begin
      REQ_VALID = 0;
      REQ_BYTE = ~REQ_BYTE;
    end
  endtask
  task automatic kick();
    START_BIT = 1;
    @(posedge MCLK);
    #1;
    START_BIT = 0;
  endtask
endmodule // master_model

// ===== verif/request_packet_command_decoder_tb.sv
// testbench for the request packet command decoder
`timescale 1ns/1ps
`include "reqdec_regs.vh"
module request_packet_command_decoder_tb;
  logic MCLK = 0;
  logic RST = 1;
  logic AWAIT_ACK = 0;
  logic DEVICE_SELECT_MATCH = 0;
  logic TAKE = 0;
  wire REQ_VALID, REQ_READY, START_BIT, CMD_VALID, ALT, PERFORM, NO_OKAY_ACK, CLOSE;
  wire WANTS_WDATA, WANTS_RDATA, WANTS_SERIAL_ADDR, USE_MASK_DATA_REGISTER_MASK, USE_MASK_DATA_REGISTER_DATA;
  wire LOAD_MASK_DATA_REGISTER, FRAMING, PKT_ODD_TICK;
  wire [7:0] REQ_BYTE, FIRST_BYTE_MASK, LAST_BYTE_MASK;
  wire [3:0] CMD;
  wire [1:0] MASK_MODE;
  wire [35:0] ADDRESS;
  wire [4:0] OCT_COUNT;
  wire [5:0] DATA_OCTBYTES, MASK_OCTBYTES;
  wire [2:0] PKT_CYCLE;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  request_packet_command_decoder u_dut (.*);
  master_model u_mst (.*);
  always #25 MCLK = ~MCLK;
  // ==========================================
  // helpers
  always @(posedge MCLK) if (++cycles > 6000) begin
    n_errors++;
    complete_run();
  end
  task automatic tick(int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask
  task automatic chk(string what, logic [35:0] exp, logic [35:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic go(logic m);
    int w = 0;
    DEVICE_SELECT_MATCH = m;
    u_mst.kick();
    while (CMD_VALID !== 1 && w++ < 40) tick(1);
    chk("valid", 1, CMD_VALID);
    chk("cycle", 3'h2, PKT_CYCLE);
    chk("odd tick", 1, PKT_ODD_TICK);
  endtask
  task automatic run(logic [3:0] o, logic [1:0] x, logic [7:0] c, logic [31:0] a, logic m);
    u_mst.push({1'b1, o, x, 1'b0, c, a}, 1);
    go(m);
  endtask
  task automatic take();
    TAKE = 1;
    tick(1);
    TAKE = 0;
    chk("drop", 0, CMD_VALID);
    tick(1);
  endtask
  function automatic logic [3:0] exp_cmd(logic [3:0] o, logic [1:0] x);
    case (o)
      4'h0, 4'h1: return x == 0 ? `CMD_RSEQ : x == 1 ? `CMD_RNSQ : `CMD_RSRV;
      4'h4, 4'h5: return `CMD_WSEQ;
      4'h8, 4'h9: return `CMD_WNSQ;
      4'hC, 4'hD: return x == 2 ? `CMD_RSRV : `CMD_WBNS;
      4'h6: return x == 0 ? `CMD_RREG : `CMD_RSRV;
      4'h7: return x == 0 ? `CMD_WREG : `CMD_RSRV;
      4'hF: return x == 0 ? `CMD_BROADCAST_REGISTER_WRITE : `CMD_RSRV;
      default: return `CMD_RSRV;
    endcase
  endfunction
  // ==========================================
  // scenarios
  task automatic decode_all();
    logic [3:0] c;
    logic m;
    logic w;
    logic [1:0] x;
    for (int k = 0; k < 64; k++) begin
      m = k[2] ^ k[3];
      x = k[1:0];
      run(k[5:2], x, 8'h07, 32'h0000_0000, m);
      c = exp_cmd(k[5:2], x);
      w = c == `CMD_WSEQ || c == `CMD_WNSQ || c == `CMD_WBNS;
      chk("cmd", c, CMD);
      chk("perform", c != `CMD_RSRV && (m || c == `CMD_BROADCAST_REGISTER_WRITE), PERFORM);
      chk("rdata", c == `CMD_RSEQ || c == `CMD_RNSQ || c == `CMD_RREG, WANTS_RDATA);
      chk("wdata", w || c == `CMD_WREG || c == `CMD_BROADCAST_REGISTER_WRITE, WANTS_WDATA);
      chk("serial", c == `CMD_WNSQ || c == `CMD_WBNS, WANTS_SERIAL_ADDR);
      chk("no okay", c == `CMD_BROADCAST_REGISTER_WRITE, NO_OKAY_ACK);
      if (c != `CMD_RSRV) chk("alt", k[2] && k[5:2] != 7 && k[5:2] != 15, ALT);
      if (w) begin
        chk("mode", x, MASK_MODE);
        chk("mdmask", x == 1, USE_MASK_DATA_REGISTER_MASK);
        chk("mddata", x == 3, USE_MASK_DATA_REGISTER_DATA);
        chk("mdload", x == 2 && m, LOAD_MASK_DATA_REGISTER);
      end
      take();
    end
  endtask
  task automatic masks();
    for (int a = 0; a < 8; a++) begin
      run(`OP_WSEQ, `XOP_NPB, {5'h03, 3'(a)}, {29'h0246_8ACF, 3'(a)}, 1);
      chk("first", 8'(8'hFF << a), FIRST_BYTE_MASK);
      chk("last", 8'hFF >> (7 - a), LAST_BYTE_MASK);
      chk("count", 5'h03, OCT_COUNT);
      chk("adr", {4'h0, 29'h0246_8ACF, 3'(a)}, ADDRESS);
      take();
    end
    u_mst.push({1'b1, `OP_WNSQ, `XOP_NPB, 1'b1, 8'h1F, 32'h0000_0200}, 1);
    go(1);
    chk("close", 1, CLOSE);
    chk("wnsq first", 8'hFF, FIRST_BYTE_MASK);
    chk("wnsq last", 8'hFF, LAST_BYTE_MASK);
    chk("wnsq data", 6'h04, DATA_OCTBYTES);
    take();
    run(`OP_WBNS, `XOP_NPB, 8'hFF, 32'h0000_0100, 1);
    chk("wbns data", 6'd32, DATA_OCTBYTES);
    chk("wbns mask", 6'd4, MASK_OCTBYTES);
    take();
    run(`OP_WSEQ, `XOP_BPB, 8'hF8, 32'h0000_0100, 1);
    chk("bpb data", 6'd16, DATA_OCTBYTES);
    chk("bpb mask", 6'd16, MASK_OCTBYTES);
    take();
  endtask
  task automatic refuse();
    u_mst.push({5'h10, 3'h0, 8'h07, 32'h0000_0040}, 1);
    AWAIT_ACK = 1;
    u_mst.kick();
    tick(3);
    chk("await", 0, FRAMING);
    AWAIT_ACK = 0;
    go(1);
    chk("late cmd", `CMD_RSEQ, CMD);
    u_mst.kick();
    tick(2);
    chk("busy", 0, FRAMING);
    take();
  endtask
  task automatic fill();
    int w = 0;
    fork
      begin
        u_mst.push({5'h10, 3'h0, 8'h07, 32'h0000_0008}, 0);
        u_mst.push({5'h17, 3'h0, 8'h07, 32'h0000_0004}, 1);
      end
    join_none
    while (REQ_READY !== 0 && w++ < 40) tick(1);
    chk("full", 0, REQ_READY);
    go(1);
    chk("first cmd", `CMD_RSEQ, CMD);
    take();
    go(1);
    chk("second cmd", `CMD_WREG, CMD);
    take();
    chk("empty", 1, REQ_READY);
  endtask
  task automatic complete_run();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge MCLK);
    #1;
    RST = 0;
    tick(1);
    decode_all();
    masks();
    refuse();
    fill();
    complete_run();
  end
endmodule // request_packet_command_decoder_tb
